/* design/bwcr_pkg.sv */
/*
 * Package of the bridge window configuration registers: register offsets,
 * field positions, reset values and the decode carrier types.
 * Assumes byte addresses on a 32-bit classic Wishbone register bus.
 */
package bwcr_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PF_WINDOW = 8'h24;
    localparam logic [7:0] OFF_PF_BOTTOM_HIGH = 8'h28;
    localparam logic [7:0] OFF_PF_TOP_HIGH = 8'h2c;
    localparam logic [7:0] OFF_IO_WINDOW_HIGH = 8'h30;
    localparam logic [7:0] OFF_CAP_POINTER = 8'h34;
    localparam logic [7:0] OFF_IRQ_LINE = 8'h3c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PF_BASE_LSB = 4;
    localparam int PF_BASE_MSB = 15;
    localparam int PF_LIMIT_LSB = 20;
    localparam int PF_LIMIT_MSB = 31;
    localparam int PF_BASE_CAP_LSB = 0;
    localparam int PF_LIMIT_CAP_LSB = 16;
    localparam int IO_BOTTOM_LSB = 0;
    localparam int IO_TOP_LSB = 16;
    localparam int CAP_PTR_LSB = 0;
    localparam int IRQ_PIN_LSB = 8;

    // ------------------------------------------------------------
    // Reset and fixed values
    // ------------------------------------------------------------
    localparam logic [11:0] PF_FIELD_RST = 12'h000;
    localparam logic [31:0] PF_HIGH_RST = 32'h0000_0000;
    localparam logic [15:0] IO_HIGH_RST = 16'h0000;
    localparam logic [3:0] ADDR_CAP_64 = 4'h1;
    localparam logic [19:0] WINDOW_LOW_ZERO = 20'h0_0000;
    localparam logic [19:0] WINDOW_LOW_ONES = 20'hf_ffff;
    localparam logic [15:0] IO_LOW_ZERO = 16'h0000;
    localparam logic [15:0] IO_LOW_ONES = 16'hffff;
    localparam logic [7:0] CAP_POINTER_VAL = 8'hdc;
    localparam logic [7:0] IRQ_PIN_VAL = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Decode carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic is_io;
        logic from_secondary;
        logic [63:0] addr;
    } bwcr_req_t;

    typedef struct packed {
        logic valid;
        logic in_window;
        logic forward;
    } bwcr_resp_t;

endpackage : bwcr_pkg

/* design/bwcr_regs.sv */
/*
 * Prefetchable and I/O window configuration registers of a two-port bridge,
 * with the forwarding window decode they steer.
 * Assumes a classic Wishbone master on the same clock, and decode requests
 * driven by logic on the same clock.
 * The low I/O base and limit bytes live outside this block, so the I/O
 * window is decoded in 64 KB granules only.
 * A limit below its base gives an empty window, not an error.
 */
// Summary of operation
// - Bits 31:20 of the prefetchable window register are a writable 12-bit top field.
// - The low 20 address bits of the prefetchable window top are taken as all ones.
// - Memory transactions are forwarded or not by comparing against the prefetch window.
// - Offset 28h holds writable bits 63:32 of the prefetch window bottom, reset to zero.
// - Offset 2Ch holds writable bits 63:32 of the prefetch window top, reset to zero.
// - The low half of offset 30h holds writable I/O bottom bits 31:16, reset to zero.
// - The high half of offset 30h holds writable I/O top bits 31:16, reset to zero.
// - The capability pointer byte at offset 34h always reads DCh.
// - The interrupt pin byte at bits 15:8 of offset 3Ch is read-only zero.
// - The low 20 bits of the prefetch bottom are zero, bits 31:20 from the base field.
`timescale 1ns/1ns

module bwcr_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire bwcr_pkg::bwcr_req_t dec_req,
    output bwcr_pkg::bwcr_resp_t dec_resp
);
    import bwcr_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 6 || ADDR_W > 12) begin : g_bad_addr_w
        $error("ADDR_W must lie between 6 and 12");
    end
    if (PF_LIMIT_MSB - PF_LIMIT_LSB != 11 || PF_BASE_MSB - PF_BASE_LSB != 11) begin : g_bad_fld
        $error("Prefetch window fields must be 12 bits wide");
    end

    // ------------------------------------------------------------
    // Byte-lane merge for partial writes
    // ------------------------------------------------------------
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [11:0] pf_base_reg;
    logic [11:0] pf_base_next;
    logic [11:0] pf_limit_reg;
    logic [11:0] pf_limit_next;
    logic [31:0] pf_bottom_high_reg;
    logic [31:0] pf_bottom_high_next;
    logic [31:0] pf_top_high_reg;
    logic [31:0] pf_top_high_next;
    logic [15:0] io_bottom_high_reg;
    logic [15:0] io_bottom_high_next;
    logic [15:0] io_top_high_reg;
    logic [15:0] io_top_high_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    logic [7:0] offset;
    logic bus_req;
    logic wr_commit;
    logic [31:0] pf_window_word;
    logic [31:0] io_window_word;
    logic [31:0] cap_word;
    logic [31:0] irq_word;
    logic [31:0] merged;
    logic [31:0] merged_io;

    // Offsets above the decoded width alias; only low byte is compared
    assign offset = 8'(wb_adr_i);
    assign bus_req = wb_cyc_i & wb_stb_i;
    // Write lands on the edge where the master sees ack high
    assign wr_commit = bus_req & wb_we_i & ack_reg;

    // ------------------------------------------------------------
    // Read views of each word
    // ------------------------------------------------------------
    always_comb begin
        pf_window_word = READ_ZERO;
        pf_window_word[PF_LIMIT_MSB:PF_LIMIT_LSB] = pf_limit_reg;
        pf_window_word[PF_LIMIT_CAP_LSB +: 4] = ADDR_CAP_64;
        pf_window_word[PF_BASE_MSB:PF_BASE_LSB] = pf_base_reg;
        pf_window_word[PF_BASE_CAP_LSB +: 4] = ADDR_CAP_64;
        io_window_word = READ_ZERO;
        io_window_word[IO_BOTTOM_LSB +: 16] = io_bottom_high_reg;
        io_window_word[IO_TOP_LSB +: 16] = io_top_high_reg;
        cap_word = READ_ZERO;
        cap_word[CAP_PTR_LSB +: 8] = CAP_POINTER_VAL;
        irq_word = READ_ZERO;
        irq_word[IRQ_PIN_LSB +: 8] = IRQ_PIN_VAL;
    end

    // ------------------------------------------------------------
    // Bus answer next state
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = rdata_reg;
        // One wait state; ack drops in the cycle after it is given
        ack_next = bus_req & ~ack_reg;
        if (ack_next) begin
            // Data is captured as the access is taken, so it stands while ack is high
            case (offset)
                OFF_PF_WINDOW: rdata_next = pf_window_word;
                OFF_PF_BOTTOM_HIGH: rdata_next = pf_bottom_high_reg;
                OFF_PF_TOP_HIGH: rdata_next = pf_top_high_reg;
                OFF_IO_WINDOW_HIGH: rdata_next = io_window_word;
                OFF_CAP_POINTER: rdata_next = cap_word;
                OFF_IRQ_LINE: rdata_next = irq_word;
                // Unmapped offsets read zero rather than raise an error
                default: rdata_next = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            rdata_reg <= READ_ZERO;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Write strobes per word
    // ------------------------------------------------------------
    logic wr_pf_window;
    logic wr_pf_bottom_high;
    logic wr_pf_top_high;
    logic wr_io_window;

    // Read-only and unmapped words have no strobe, so writes to them are lost
    assign wr_pf_window = wr_commit && (offset == OFF_PF_WINDOW);
    assign wr_pf_bottom_high = wr_commit && (offset == OFF_PF_BOTTOM_HIGH);
    assign wr_pf_top_high = wr_commit && (offset == OFF_PF_TOP_HIGH);
    assign wr_io_window = wr_commit && (offset == OFF_IO_WINDOW_HIGH);

    // ------------------------------------------------------------
    // Prefetch window next state
    // ------------------------------------------------------------
    always_comb begin
        pf_base_next = pf_base_reg;
        pf_limit_next = pf_limit_reg;
        pf_bottom_high_next = pf_bottom_high_reg;
        pf_top_high_next = pf_top_high_reg;
        merged = READ_ZERO;
        if (wr_pf_window) begin
            // Merging with the read view keeps the read-only codes out of the fields
            merged = lane_merge(pf_window_word, wb_dat_i, wb_sel_i);
            pf_limit_next = merged[PF_LIMIT_MSB:PF_LIMIT_LSB];
            pf_base_next = merged[PF_BASE_MSB:PF_BASE_LSB];
        end
        if (wr_pf_bottom_high) begin
            pf_bottom_high_next = lane_merge(pf_bottom_high_reg, wb_dat_i,
                wb_sel_i);
        end
        if (wr_pf_top_high) begin
            pf_top_high_next = lane_merge(pf_top_high_reg, wb_dat_i,
                wb_sel_i);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pf_base_reg <= PF_FIELD_RST;
            pf_limit_reg <= PF_FIELD_RST;
            pf_bottom_high_reg <= PF_HIGH_RST;
            pf_top_high_reg <= PF_HIGH_RST;
        end else begin
            pf_base_reg <= pf_base_next;
            pf_limit_reg <= pf_limit_next;
            pf_bottom_high_reg <= pf_bottom_high_next;
            pf_top_high_reg <= pf_top_high_next;
        end
    end

    // ------------------------------------------------------------
    // I/O window next state
    // ------------------------------------------------------------
    always_comb begin
        io_bottom_high_next = io_bottom_high_reg;
        io_top_high_next = io_top_high_reg;
        merged_io = READ_ZERO;
        if (wr_io_window) begin
            merged_io = lane_merge(io_window_word, wb_dat_i, wb_sel_i);
            io_bottom_high_next = merged_io[IO_BOTTOM_LSB +: 16];
            io_top_high_next = merged_io[IO_TOP_LSB +: 16];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            io_bottom_high_reg <= IO_HIGH_RST;
            io_top_high_reg <= IO_HIGH_RST;
        end else begin
            io_bottom_high_reg <= io_bottom_high_next;
            io_top_high_reg <= io_top_high_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // ------------------------------------------------------------
    // Forwarding window decode
    // ------------------------------------------------------------
    logic [63:0] pf_bottom;
    logic [63:0] pf_top;
    logic [31:0] io_bottom;
    logic [31:0] io_top;
    logic hit;
    bwcr_resp_t resp_reg;
    bwcr_resp_t resp_next;

    // Full-width window ends assembled from the register fields
    assign pf_bottom = {pf_bottom_high_reg, pf_base_reg, WINDOW_LOW_ZERO};
    assign pf_top = {pf_top_high_reg, pf_limit_reg, WINDOW_LOW_ONES};
    // Lower I/O fields live elsewhere; only the 64 KB granule is decoded here
    assign io_bottom = {io_bottom_high_reg, IO_LOW_ZERO};
    assign io_top = {io_top_high_reg, IO_LOW_ONES};

    // ------------------------------------------------------------
    // Window compare terms
    // ------------------------------------------------------------
    logic pf_above_bottom;
    logic pf_below_top;
    logic io_upper_clear;
    logic io_above_bottom;
    logic io_below_top;
    logic pf_hit;
    logic io_hit;

    // Both ends count as inside the window
    assign pf_above_bottom = dec_req.addr >= pf_bottom;
    assign pf_below_top = dec_req.addr <= pf_top;
    // I/O space is 32 bits; higher address bits must be clear
    assign io_upper_clear = dec_req.addr[63:32] == PF_HIGH_RST;
    assign io_above_bottom = dec_req.addr[31:0] >= io_bottom;
    assign io_below_top = dec_req.addr[31:0] <= io_top;
    assign pf_hit = pf_above_bottom & pf_below_top;
    assign io_hit = io_upper_clear & io_above_bottom & io_below_top;

    always_comb begin
        resp_next = resp_reg;
        hit = 1'b0;
        resp_next.valid = dec_req.valid;
        if (dec_req.valid) begin
            if (dec_req.is_io) begin
                hit = io_hit;
            end else begin
                hit = pf_hit;
            end
            resp_next.in_window = hit;
            // Downstream inside the window, upstream outside it
            resp_next.forward = dec_req.from_secondary ? ~hit : hit;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resp_reg <= '0;
        end else begin
            resp_reg <= resp_next;
        end
    end

    assign dec_resp = resp_reg;

endmodule : bwcr_regs

/* sim/bwcr_asserts.sv */
/* Checker of the window register block: bus answer, fixed fields, decode.
   Assumes bus requests are held until ack; bound to bwcr_regs. */
`timescale 1ns/1ns
module bwcr_asserts #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire bwcr_pkg::bwcr_req_t dec_req,
    input wire bwcr_pkg::bwcr_resp_t dec_resp
);
    import bwcr_pkg::*;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic rd;
    logic [7:0] off;
    assign rd = wb_ack_o && !wb_we_i;
    assign off = 8'(wb_adr_i);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Bus answer missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack longer than one cycle");
    a_cap_fixed: assert property (rd && off == OFF_CAP_POINTER |-> wb_dat_o == 32'h0000_00dc)
        else $error("Capability pointer wrong");
    a_irq_zero: assert property (rd && off == OFF_IRQ_LINE |-> wb_dat_o[15:8] == 8'h00)
        else $error("Interrupt pin not zero");
    a_cap_bits: assert property (rd && off == OFF_PF_WINDOW |->
        wb_dat_o[19:16] == 4'h1 && wb_dat_o[3:0] == 4'h1)
        else $error("Addressing code wrong");
    a_resp_valid: assert property (dec_req.valid |=> dec_resp.valid)
        else $error("Decode answer missing");
    a_resp_idle: assert property (!dec_req.valid |=> !dec_resp.valid
        && $stable(dec_resp.in_window) && $stable(dec_resp.forward))
        else $error("Decode answer without request");
    a_fwd_sense: assert property (dec_resp.valid |->
        dec_resp.forward == (dec_resp.in_window ^ $past(dec_req.from_secondary)))
        else $error("Forward sense wrong");
    a_io_upper: assert property (dec_req.valid && dec_req.is_io
        && dec_req.addr[63:32] != 32'h0 |=> !dec_resp.in_window)
        else $error("I/O hit above 4G");
    c_pf_read: cover property (rd && off == OFF_PF_WINDOW);
    c_hit: cover property (dec_resp.valid && dec_resp.in_window);
    c_miss_fwd: cover property (dec_resp.valid && !dec_resp.in_window && dec_resp.forward);
endmodule : bwcr_asserts

bind bwcr_regs bwcr_asserts #(.ADDR_W(ADDR_W)) chk_u (.clk(clk), .nrst(nrst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dec_req(dec_req), .dec_resp(dec_resp));

/* sim/bwcr_peer.sv */
/* Far-side source of decode requests.
   Assumes the bench hands it one request at a time. */
`timescale 1ns/1ns
module bwcr_peer (
    input wire logic clk,
    input wire bwcr_pkg::bwcr_req_t cmd,
    output bwcr_pkg::bwcr_req_t dec_req
);
    import bwcr_pkg::*;
    // ------------------------------------------------------------
    // Idle pattern
    // ------------------------------------------------------------
    logic [63:0] junk_reg = 64'h5a5a_0f0f_a5a5_f0f0;
    // Idle lines toggle so a stale address can never pass for a held one
    always_ff @(posedge clk) junk_reg <= ~junk_reg;
    assign dec_req = cmd.valid ? cmd : {1'b0, junk_reg[1:0], junk_reg};
endmodule : bwcr_peer

/* sim/bwcr_regs_test.sv */
/* Bench of the window register block: bus reads and writes, decode probes.
   Assumes the checker is bound and bwcr_peer drives decode requests. */
`timescale 1ns/1ns
module bwcr_regs_test;
    import bwcr_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 0;
    logic nrst = 0;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rdat;
    logic ack;
    bwcr_req_t cmd = '0;
    bwcr_req_t dec_req;
    bwcr_resp_t resp;
    int failures = 0;
    int tests_run = 0;
    int seed = 50;
    logic [7:0] offs [7] = '{8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h3c, 8'h40};
    logic [31:0] mdl [7] = '{32'h0001_0001, 32'h0, 32'h0, 32'h0, 32'h0000_00dc, 32'h0, 32'h0};
    always #2 clk = ~clk;
    bwcr_regs #(.ADDR_W(8)) dut_u (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .dec_req(dec_req), .dec_resp(resp));
    bwcr_peer peer_u (.clk(clk), .cmd(cmd), .dec_req(dec_req));
    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task stop_test;
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) failures++;
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic put(input int j, input logic [31:0] d, input logic [3:0] s);
        wb(1'b1, offs[j], d, s);
        for (int b = 0; b < 4; b++) if (s[b] && j < 4) mdl[j][8*b +: 8] = d[8*b +: 8];
        if (j == 0) mdl[0] = mdl[0] & 32'hfff0_fff0 | 32'h0001_0001;
    endtask : put
    function automatic logic [63:0] win_lim(input logic io, input logic top);
        if (io) return top ? {32'h0, mdl[3][31:16], 16'hffff} : {32'h0, mdl[3][15:0], 16'h0};
        return top ? {mdl[2], mdl[0][31:20], 20'hf_ffff} : {mdl[1], mdl[0][15:4], 20'h0};
    endfunction : win_lim
    task automatic dec(input logic io, input logic sec, input logic [63:0] a);
        logic e;
        e = a >= win_lim(io, 1'b0) && a <= win_lim(io, 1'b1);
        @(posedge clk);
        cmd <= '{valid: 1'b1, is_io: io, from_secondary: sec, addr: a};
        @(posedge clk);
        cmd.valid <= 1'b0;
        #1;
        chk({30'h0, resp.valid, resp.in_window}, {30'h0, 1'b1, e});
        chk({31'h0, resp.forward}, {31'h0, e ^ sec});
    endtask : dec
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        logic [63:0] pr [5];
        logic [15:0] iob;
        int j;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 67; i++) begin
            j = i < 7 ? i : $unsigned($random(seed)) % 7;
            if (i >= 7) put(j, $random(seed), 4'($random(seed)));
            wb(1'b0, offs[j], 32'h0, 4'hf);
            chk(rdat, mdl[j]);
        end
        // A reset in mid-run must clear every writable field again
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        mdl = '{32'h0001_0001, 32'h0, 32'h0, 32'h0, 32'h0000_00dc, 32'h0, 32'h0};
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, offs[i], 32'h0, 4'hf);
            chk(rdat, mdl[i]);
        end
        for (int t = 0; t < 4; t++) begin
            iob = 16'($random(seed)) & 16'h7fff | 16'h0001;
            put(0, $random(seed), 4'hf);
            put(1, $random(seed) & 32'h7fff_ffff | 32'h1, 4'hf);
            // Equal upper halves at t = 0 leave base against limit to decide
            put(2, mdl[1] + 32'(t), 4'hf);
            put(3, {iob + 16'h0100, iob}, 4'hf);
            for (int io = 0; io < 2; io++) begin
                pr = '{win_lim(1'(io), 1'b0) - 1, win_lim(1'(io), 1'b0), win_lim(1'(io), 1'b1),
                    win_lim(1'(io), 1'b1) + 1, win_lim(1'(io), 1'b0) | 64'h1_0000_0000};
                for (int k = 0; k < 10; k++) dec(1'(io), 1'(k), pr[k / 2]);
            end
        end
        stop_test();
    end
    initial begin
        #40000;
        failures++;
        stop_test();
    end
endmodule : bwcr_regs_test
